//--- hw/hmic_top.sv
`timescale 1ns/10ps
// Contract
// - Mask bits 3-5 block tach two, chassis, overtemp
// - Hot default mode: re-flag each conversion while hot
// - Hot one-time mode: flag on crossing and recovery
// - Overtemp default mode: re-flag each conversion while over
// - Overtemp one-time mode: flag on crossing and recovery
// - Bits 0,1: one level input, zero counting
// - Field 3:2 divides tach one by 1,2,4,8
// - Field 5:4 divides tach two by 1,2,4,8
// - Bit 2 selects tach one level polarity
// - Bit 4 selects tach two level polarity
// - Bit 6 alone: shared pin is overtemp alert
// - Bit 7 set: shared pin is reset output
// - Bits 6,7 clear: shared pin disabled
// - Config register resets to 0001 0100
// - Hot flag mode chosen by mask bit 6
module hmic_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic hot_above_limit,
  input wire logic hot_below_hyst,
  input wire logic ot_above_limit,
  input wire logic ot_below_hyst,
  input wire logic tach_one_count_fault,
  input wire logic tach_two_count_fault,
  input wire logic tach_input_one,
  input wire logic tach_input_two,
  input wire logic chassis_intrusion_input,
  input wire logic reset_request,
  output logic int_out,
  output logic tach_one_level_mode,
  output logic tach_two_level_mode,
  output logic [1:0] tach_one_div_sel,
  output logic [1:0] tach_two_div_sel,
  output logic overtemp_alert_output,
  output logic alert_pin_oe,
  output logic alert_pin_out
);
  // ------------------------------------------------------------
  // Registers and internal state
  // ------------------------------------------------------------
  logic [7:0] mask_two_reg; // interrupt_mask_two
  logic [7:0] fan_cfg_reg; // fan_divisor_pin_config
  logic [7:0] rdata_reg; // Registered read data
  logic tach_one_flag_reg; // Sticky tach one status
  logic tach_two_flag_reg; // Sticky tach two status
  logic chassis_flag_reg; // Sticky chassis intrusion status
  logic hot_flag; // From hot-limit tracker
  logic ot_flag; // From overtemp-limit tracker
  logic int_reg; // Interrupt output flop
  logic alert_oe_reg; // Shared pin drive enable
  logic alert_active_reg; // Overtemp comparator level
  logic alert_out_reg; // Alert-mode view of the shared pin
  logic [7:0] status_two; // Assembled status view
  logic status_read; // Read of the status register this cycle
  logic tach_one_level_hit; // Active level on tach one in level mode
  logic tach_two_level_hit; // Active level on tach two in level mode
  logic tach_one_set;
  logic tach_two_set;

  // ------------------------------------------------------------
  // Configuration and mask registers
  // ------------------------------------------------------------

  // Config register: divisors, pin modes, shared-pin select
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fan_cfg_reg <= hmic_pkg::FAN_CFG_RESET;
    end else if (reg_wr && reg_addr == hmic_pkg::ADDR_FAN_CFG) begin
      fan_cfg_reg <= reg_wdata;
    end
  end

  // Mask register, including the two temperature mode selects
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mask_two_reg <= hmic_pkg::MASK_TWO_RESET;
    end else if (reg_wr && reg_addr == hmic_pkg::ADDR_MASK_TWO) begin
      mask_two_reg <= reg_wdata;
    end
  end

  // Status reads clear the flags they return
  assign status_read = reg_rd && (reg_addr == hmic_pkg::ADDR_STATUS_TWO);

  // ------------------------------------------------------------
  // Temperature flags
  // ------------------------------------------------------------

  // Hot-limit flag; mode from mask bit 6
  hmic_temp_flag u_hot_flag (
    .ref_clk(ref_clk),
    .srst(srst),
    .one_time_mode(mask_two_reg[hmic_pkg::BIT_HOT_MODE]),
    .conv_done(conv_done),
    .above_limit(hot_above_limit),
    .below_hyst(hot_below_hyst),
    .status_read(status_read),
    .flag_reg(hot_flag)
  );

  // Overtemp-limit flag; mode from mask bit 7
  hmic_temp_flag u_ot_flag (
    .ref_clk(ref_clk),
    .srst(srst),
    .one_time_mode(mask_two_reg[hmic_pkg::BIT_OT_MODE]),
    .conv_done(conv_done),
    .above_limit(ot_above_limit),
    .below_hyst(ot_below_hyst),
    .status_read(status_read),
    .flag_reg(ot_flag)
  );

  // ------------------------------------------------------------
  // Tachometer and chassis flags
  // ------------------------------------------------------------

  // Level mode: polarity bit one means low is active
  assign tach_one_level_hit = fan_cfg_reg[hmic_pkg::CFG_DIV_ONE_LO] ? !tach_input_one : tach_input_one;
  assign tach_two_level_hit = fan_cfg_reg[hmic_pkg::CFG_DIV_TWO_LO] ? !tach_input_two : tach_input_two;

  // Source depends on pin mode: level check or count-limit fault
  assign tach_one_set = fan_cfg_reg[hmic_pkg::CFG_TACH_ONE_LEVEL] ? tach_one_level_hit : tach_one_count_fault;
  assign tach_two_set = fan_cfg_reg[hmic_pkg::CFG_TACH_TWO_LEVEL] ? tach_two_level_hit : tach_two_count_fault;

  // Tach one status; a set beats a clearing read
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tach_one_flag_reg <= 1'b0;
    end else if (tach_one_set) begin
      tach_one_flag_reg <= 1'b1;
    end else if (status_read) begin
      tach_one_flag_reg <= 1'b0;
    end
  end

  // Tach two status; a held level keeps it set through a clearing read
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tach_two_flag_reg <= 1'b0;
    end else if (tach_two_set) begin
      tach_two_flag_reg <= 1'b1;
    end else if (status_read) begin
      tach_two_flag_reg <= 1'b0;
    end
  end

  // Chassis intrusion status, set while the input is high
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chassis_flag_reg <= 1'b0;
    end else if (chassis_intrusion_input) begin
      chassis_flag_reg <= 1'b1;
    end else if (status_read) begin
      chassis_flag_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Status view and interrupt output
  // ------------------------------------------------------------

  // Board-temperature input lives outside this block and reads zero
  always_comb begin
    status_two = hmic_pkg::STATUS_RESET;
    status_two[hmic_pkg::BIT_HOT] = hot_flag;
    status_two[hmic_pkg::BIT_TACH_ONE] = tach_one_flag_reg;
    status_two[hmic_pkg::BIT_TACH_TWO] = tach_two_flag_reg;
    status_two[hmic_pkg::BIT_CHASSIS] = chassis_flag_reg;
    status_two[hmic_pkg::BIT_OT_LIMIT] = ot_flag;
  end

  // Interrupt: any set flag whose mask bit is zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      int_reg <= 1'b0;
    end else begin
      int_reg <= |(status_two[hmic_pkg::BIT_OT_LIMIT:hmic_pkg::BIT_HOT]
                   & ~mask_two_reg[hmic_pkg::BIT_OT_LIMIT:hmic_pkg::BIT_HOT]);
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_reg <= hmic_pkg::READ_ZERO;
    end else if (reg_rd) begin
      if (reg_addr == hmic_pkg::ADDR_STATUS_TWO) begin
        rdata_reg <= status_two;
      end else if (reg_addr == hmic_pkg::ADDR_MASK_TWO) begin
        rdata_reg <= mask_two_reg;
      end else if (reg_addr == hmic_pkg::ADDR_FAN_CFG) begin
        rdata_reg <= fan_cfg_reg;
      end else begin
        rdata_reg <= hmic_pkg::READ_ZERO;
      end
    end
  end

  // ------------------------------------------------------------
  // Shared reset / overtemp alert pin
  // ------------------------------------------------------------

  // Comparator level: on above limit, off once under hysteresis
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alert_active_reg <= 1'b0;
    end else if (conv_done && ot_above_limit) begin
      alert_active_reg <= 1'b1;
    end else if (conv_done && ot_below_hyst) begin
      alert_active_reg <= 1'b0;
    end
  end

  // Open-drain pin: drive low only when the selected function asserts
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alert_oe_reg <= 1'b0;
    end else if (fan_cfg_reg[hmic_pkg::CFG_RESET_PIN_SEL]) begin
      alert_oe_reg <= reset_request;
    end else if (fan_cfg_reg[hmic_pkg::CFG_ALERT_PIN_SEL]) begin
      alert_oe_reg <= alert_active_reg;
    end else begin
      alert_oe_reg <= 1'b0;
    end
  end

  // Alert-mode view; kept as its own flop so the output never glitches on a mode write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alert_out_reg <= 1'b0;
    end else if (!fan_cfg_reg[hmic_pkg::CFG_RESET_PIN_SEL] && fan_cfg_reg[hmic_pkg::CFG_ALERT_PIN_SEL]) begin
      alert_out_reg <= alert_active_reg;
    end else begin
      alert_out_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Output assignments, all from flops except the tied-low pin data
  // ------------------------------------------------------------
  assign reg_rdata = rdata_reg;
  assign int_out = int_reg;
  assign tach_one_level_mode = fan_cfg_reg[hmic_pkg::CFG_TACH_ONE_LEVEL];
  assign tach_two_level_mode = fan_cfg_reg[hmic_pkg::CFG_TACH_TWO_LEVEL];
  assign tach_one_div_sel = fan_cfg_reg[hmic_pkg::CFG_DIV_ONE_HI:hmic_pkg::CFG_DIV_ONE_LO];
  assign tach_two_div_sel = fan_cfg_reg[hmic_pkg::CFG_DIV_TWO_HI:hmic_pkg::CFG_DIV_TWO_LO];
  assign overtemp_alert_output = alert_out_reg;
  assign alert_pin_oe = alert_oe_reg;
  assign alert_pin_out = 1'b0; // Open drain: low whenever driven
endmodule

//--- hw/hmic_pkg.sv
package hmic_pkg;
  // ------------------------------------------------------------
  // Register offsets on the register access port
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h02; // Second status, read clears
  localparam logic [7:0] ADDR_MASK_TWO = 8'h04; // interrupt_mask_two
  localparam logic [7:0] ADDR_FAN_CFG = 8'h05; // fan_divisor_pin_config

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] MASK_TWO_RESET = 8'h00;
  localparam logic [7:0] FAN_CFG_RESET = 8'h14; // Divide by 2 on both, pin off
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ------------------------------------------------------------
  // Status and mask bit positions (shared layout)
  // ------------------------------------------------------------
  localparam int BIT_HOT = 0;
  localparam int BIT_BOARD = 1;
  localparam int BIT_TACH_ONE = 2;
  localparam int BIT_TACH_TWO = 3;
  localparam int BIT_CHASSIS = 4;
  localparam int BIT_OT_LIMIT = 5;
  localparam int BIT_HOT_MODE = 6; // In mask register only
  localparam int BIT_OT_MODE = 7; // In mask register only

  // ------------------------------------------------------------
  // fan_divisor_pin_config fields
  // ------------------------------------------------------------
  localparam int CFG_TACH_ONE_LEVEL = 0;
  localparam int CFG_TACH_TWO_LEVEL = 1;
  localparam int CFG_DIV_ONE_LO = 2; // Also level polarity of tach one
  localparam int CFG_DIV_ONE_HI = 3;
  localparam int CFG_DIV_TWO_LO = 4; // Also level polarity of tach two
  localparam int CFG_DIV_TWO_HI = 5;
  localparam int CFG_ALERT_PIN_SEL = 6;
  localparam int CFG_RESET_PIN_SEL = 7;

  // ------------------------------------------------------------
  // Temperature flag tracking states
  // ------------------------------------------------------------
  typedef enum logic {
    HMIC_TEMP_NORMAL,
    HMIC_TEMP_OVER
  } hmic_temp_e;
endpackage

//--- hw/hmic_temp_flag.sv
`timescale 1ns/10ps
// One temperature status flag with repeating or one-time behaviour
module hmic_temp_flag (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic one_time_mode,
  input wire logic conv_done,
  input wire logic above_limit,
  input wire logic below_hyst,
  input wire logic status_read,
  output logic flag_reg
);
  // ------------------------------------------------------------
  // Over-limit tracking
  // ------------------------------------------------------------
  hmic_pkg::hmic_temp_e state_reg; // Above limit, not yet back under hysteresis
  hmic_pkg::hmic_temp_e state_next;
  logic set_event; // Flag set at this conversion

  // Next state and set decision, only at completed conversions
  always_comb begin
    state_next = state_reg;
    set_event = 1'b0;
    case (state_reg)
      hmic_pkg::HMIC_TEMP_NORMAL: begin
        if (conv_done && above_limit) begin
          // Both modes flag the upward crossing
          state_next = hmic_pkg::HMIC_TEMP_OVER;
          set_event = 1'b1;
        end
      end
      hmic_pkg::HMIC_TEMP_OVER: begin
        if (conv_done && below_hyst) begin
          state_next = hmic_pkg::HMIC_TEMP_NORMAL;
          // One-time mode flags the return under hysteresis
          set_event = one_time_mode;
        end else if (conv_done) begin
          // Repeating mode flags every conversion while still hot
          set_event = !one_time_mode;
        end
      end
      default: begin
        state_next = hmic_pkg::HMIC_TEMP_NORMAL;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= hmic_pkg::HMIC_TEMP_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // Sticky flag; a set in the read cycle wins so no event is lost
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flag_reg <= 1'b0;
    end else if (set_event) begin
      flag_reg <= 1'b1;
    end else if (status_read) begin
      flag_reg <= 1'b0;
    end
  end
endmodule

//--- tb/hmic_top_chk.sv
`timescale 1ns/10ps
// Port-level checker for hmic_top
module hmic_top_chk (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic hot_above_limit,
  input wire logic ot_above_limit,
  input wire logic ot_below_hyst,
  input wire logic reset_request,
  input wire logic int_out,
  input wire logic tach_one_level_mode,
  input wire logic tach_two_level_mode,
  input wire logic [1:0] tach_one_div_sel,
  input wire logic [1:0] tach_two_div_sel,
  input wire logic overtemp_alert_output,
  input wire logic alert_pin_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Shadow copies of the writable registers
  // ----------------------------------------
  logic [7:0] cfg_sh; // Config copy
  logic [7:0] mask_sh; // Mask copy
  logic ot_over; // Overtemp above-limit state, needed to spot crossings
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_sh <= hmic_pkg::FAN_CFG_RESET;
      mask_sh <= hmic_pkg::MASK_TWO_RESET;
    end else if (reg_wr) begin
      if (reg_addr == hmic_pkg::ADDR_FAN_CFG) cfg_sh <= reg_wdata;
      if (reg_addr == hmic_pkg::ADDR_MASK_TWO) mask_sh <= reg_wdata;
    end
  end
  // Limit checked before hysteresis, as the design does
  always_ff @(posedge ref_clk) begin
    if (srst) ot_over <= 1'b0;
    else if (conv_done && ot_above_limit) ot_over <= 1'b1;
    else if (conv_done && ot_below_hyst) ot_over <= 1'b0;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_int_late;
    ##2 int_out;
  endsequence
  property p_div_one;
    reg_wr && reg_addr == hmic_pkg::ADDR_FAN_CFG |=> tach_one_div_sel == $past(reg_wdata[3:2]);
  endproperty
  a_div_one: assert property (p_div_one) else $error("tach one divider wrong");
  property p_div_two;
    reg_wr && reg_addr == hmic_pkg::ADDR_FAN_CFG |=> tach_two_div_sel == $past(reg_wdata[5:4]);
  endproperty
  a_div_two: assert property (p_div_two) else $error("tach two divider wrong");
  property p_levels;
    reg_wr && reg_addr == hmic_pkg::ADDR_FAN_CFG |=>
      {tach_two_level_mode, tach_one_level_mode} == $past(reg_wdata[1:0]);
  endproperty
  a_levels: assert property (p_levels) else $error("tach mode wrong");
  property p_pin_off;
    $past(cfg_sh[7:6]) == 2'h0 |-> !alert_pin_oe && !overtemp_alert_output;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disabled pin driven");
  property p_pin_reset;
    $past(cfg_sh[7]) |-> alert_pin_oe == $past(reset_request) && !overtemp_alert_output;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin mode wrong");
  property p_pin_alert;
    $past(cfg_sh[7:6]) == 2'h1 |-> alert_pin_oe == $past(ot_over) && overtemp_alert_output == $past(ot_over);
  endproperty
  a_pin_alert: assert property (p_pin_alert) else $error("alert pin mode wrong");
  property p_all_masked;
    $past(mask_sh[5:0]) == 6'h3f |-> !int_out;
  endproperty
  a_all_masked: assert property (p_all_masked) else $error("masked flag reached int");
  property p_ot_repeat;
    conv_done && ot_above_limit && !mask_sh[7] && !mask_sh[5] |-> s_int_late;
  endproperty
  a_ot_repeat: assert property (p_ot_repeat) else $error("overtemp repeat missing");
  property p_hot_repeat;
    conv_done && hot_above_limit && !mask_sh[6] && !mask_sh[0] |-> s_int_late;
  endproperty
  a_hot_repeat: assert property (p_hot_repeat) else $error("hot repeat missing");
  property p_ot_once;
    conv_done && mask_sh[7] && !mask_sh[5] && (ot_above_limit ? !ot_over : (ot_below_hyst && ot_over))
      |-> s_int_late;
  endproperty
  a_ot_once: assert property (p_ot_once) else $error("overtemp one-time event missing");
  property p_rd_cfg;
    reg_rd && reg_addr == hmic_pkg::ADDR_FAN_CFG |=> reg_rdata == $past(cfg_sh);
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config readback wrong");
endmodule

//--- tb/tb_hmic_top.sv
`timescale 1ns/10ps
module tb_hmic_top;
  localparam logic [7:0] A_ST = hmic_pkg::ADDR_STATUS_TWO;
  localparam logic [7:0] A_MK = hmic_pkg::ADDR_MASK_TWO;
  localparam logic [7:0] A_CF = hmic_pkg::ADDR_FAN_CFG;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic conv_done = 1'b0;
  logic hot_above_limit = 1'b0;
  logic hot_below_hyst = 1'b0;
  logic ot_above_limit = 1'b0;
  logic ot_below_hyst = 1'b0;
  logic tach_one_count_fault = 1'b0;
  logic tach_two_count_fault = 1'b0;
  logic tach_input_one = 1'b0;
  logic tach_input_two = 1'b0;
  logic chassis_intrusion_input = 1'b0;
  logic reset_request = 1'b0;
  logic int_out, tach_one_level_mode, tach_two_level_mode, overtemp_alert_output, alert_pin_oe, alert_pin_out;
  logic [1:0] tach_one_div_sel, tach_two_div_sel;
  logic [7:0] exp_q[$]; // Read results awaited, oldest first
  logic rd_pend = 1'b0; // Read data due this edge
  logic [7:0] v;
  logic [15:0] lfsr = 16'h27e5;
  int miscompares = 0;
  int samples_checked = 0;
  hmic_top hmic_top_inst (.ref_clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .conv_done,
    .hot_above_limit, .hot_below_hyst, .ot_above_limit, .ot_below_hyst, .tach_one_count_fault,
    .tach_two_count_fault, .tach_input_one, .tach_input_two, .chassis_intrusion_input, .reset_request,
    .int_out, .tach_one_level_mode, .tach_two_level_mode, .tach_one_div_sel, .tach_two_div_sel,
    .overtemp_alert_output, .alert_pin_oe, .alert_pin_out);
  always #25 ref_clk = ~ref_clk;
  // ----------------------------------------
  // Helpers; inputs move on the falling edge
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  // Expected data is queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge ref_clk);
    reg_rd = 1'b0;
  endtask
  // Levels: hot above, hot below, overtemp above, overtemp below
  task automatic conv(input logic [3:0] lv);
    @(negedge ref_clk);
    {hot_above_limit, hot_below_hyst, ot_above_limit, ot_below_hyst} = lv;
    conv_done = 1'b1;
    @(negedge ref_clk);
    conv_done = 1'b0;
  endtask
  // One-cycle pulse on: tach two fault, chassis, tach pin one, tach pin two
  task automatic tog(input logic [3:0] m);
    @(negedge ref_clk);
    {tach_two_count_fault, chassis_intrusion_input, tach_input_one, tach_input_two} =
      {tach_two_count_fault, chassis_intrusion_input, tach_input_one, tach_input_two} ^ m;
    @(negedge ref_clk);
    {tach_two_count_fault, chassis_intrusion_input, tach_input_one, tach_input_two} =
      {tach_two_count_fault, chassis_intrusion_input, tach_input_one, tach_input_two} ^ m;
  endtask
  task automatic chk_pins(input logic [2:0] e);
    @(negedge ref_clk);
    chk({4'h0, alert_pin_out, overtemp_alert_output, int_out, alert_pin_oe}, {5'h00, e});
  endtask
  // Conversion, then a clearing status read
  task automatic step(input logic [3:0] lv, input logic [7:0] st);
    conv(lv);
    chk_pins({1'b0, |st, 1'b0});
    rd(A_ST, st);
    chk_pins(3'h0);
  endtask
  // Read monitor: strobe noted at the edge, data compared once settled at the falling edge
  always @(posedge ref_clk) rd_pend <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_pend) chk(reg_rdata, exp_q.pop_front());
  end
  // Run is under two hundred cycles; this is ample
  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk) srst = 1'b0;
    chk({tach_one_level_mode, tach_two_level_mode, tach_one_div_sel, tach_two_div_sel, alert_pin_oe, int_out},
      8'h14);
    rd(A_CF, 8'h14);
    rd(A_MK, 8'h00);
    rd(8'h3c, 8'h00);
    // Every divider code, random pin mode and reset request
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      v = {lfsr[7:6], k[2:1], k[1:0], 2'h0};
      reset_request = lfsr[9];
      wr(A_CF, v);
      @(negedge ref_clk);
      chk({tach_one_div_sel, tach_two_div_sel, alert_pin_oe, 3'h0}, {v[3:2], v[5:4], v[7] & lfsr[9], 3'h0});
      rd(A_CF, v);
    end
    wr(A_CF, 8'h54);
    conv(4'h2);
    chk_pins(3'h7);
    rd(A_ST, 8'h20);
    conv(4'h1);
    chk_pins(3'h0);
    wr(A_CF, 8'h14);
    step(4'ha, 8'h21);
    step(4'ha, 8'h21);
    step(4'h5, 8'h00);
    wr(A_MK, 8'hc0);
    step(4'ha, 8'h21);
    step(4'ha, 8'h00);
    step(4'h5, 8'h21);
    step(4'h5, 8'h00);
    wr(A_MK, 8'h40);
    step(4'ha, 8'h21);
    step(4'ha, 8'h20);
    step(4'h5, 8'h01);
    // Masked flags set but stay off the interrupt; unmasked chassis then reaches it
    wr(A_MK, 8'h3f);
    tog(4'hc);
    conv(4'h2);
    chk_pins(3'h0);
    rd(A_ST, 8'h38);
    wr(A_MK, 8'h28);
    tog(4'h4);
    chk_pins(3'h2);
    rd(A_ST, 8'h10);
    // Level-sensitive tach pins, both polarities
    wr(A_MK, 8'h00);
    // Count mode: tach one fault pulse reaches the status
    @(negedge ref_clk) tach_one_count_fault = 1'b1;
    @(negedge ref_clk) tach_one_count_fault = 1'b0;
    rd(A_ST, 8'h04);
    wr(A_CF, 8'h03);
    chk({6'h00, tach_one_level_mode, tach_two_level_mode}, 8'h03);
    tog(4'h2);
    rd(A_ST, 8'h04);
    wr(A_CF, 8'h14);
    @(negedge ref_clk) {tach_input_one, tach_input_two} = 2'h3;
    wr(A_CF, 8'h17);
    rd(A_ST, 8'h00);
    tog(4'h1);
    rd(A_ST, 8'h08);
    // Mid-run reset brings the reset values back
    @(negedge ref_clk) srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    chk_pins(3'h0);
    rd(A_CF, 8'h14);
    rd(A_MK, 8'h00);
    repeat (3) @(negedge ref_clk);
    tally_and_finish();
  end
endmodule
bind hmic_top hmic_top_chk hmic_top_chk_inst (.ref_clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata, .conv_done, .hot_above_limit, .ot_above_limit, .ot_below_hyst, .reset_request, .int_out,
  .tach_one_level_mode, .tach_two_level_mode, .tach_one_div_sel, .tach_two_div_sel, .overtemp_alert_output,
  .alert_pin_oe);
